// ---- design/uwfd_pkg.sv ----
`default_nettype none
package uwfd_pkg;
  // bit clock derives from the system clock, 16 ticks per bit
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_DEF = 115_200;
  localparam int unsigned OVS = 16;
  localparam logic [15:0] DIV_RST = 16'(CLK_HZ / (OVS * BAUD_DEF) - 1);
  localparam logic [3:0] TK_MID = 4'h7;
  localparam logic [3:0] TK_END = 4'hF;
  // fifo geometry
  localparam int unsigned DEPTH = 16;
  localparam logic [4:0] CAP_FULL = 5'h10;
  localparam logic [4:0] CAP_ONE = 5'h01;
  // trigger levels in entries: 1/8, 1/4, 1/2, 3/4, 7/8 of sixteen
  localparam logic [4:0] LVL_1_8 = 5'h02;
  localparam logic [4:0] LVL_1_4 = 5'h04;
  localparam logic [4:0] LVL_1_2 = 5'h08;
  localparam logic [4:0] LVL_3_4 = 5'h0C;
  localparam logic [4:0] LVL_7_8 = 5'h0E;
  // register byte offsets
  localparam logic [4:0] A_DATA = 5'h00;
  localparam logic [4:0] A_CTRL = 5'h04;
  localparam logic [4:0] A_BAUD = 5'h08;
  localparam logic [4:0] A_STAT = 5'h0C;
  localparam logic [4:0] A_EVT = 5'h10;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b011,
    ST_PAR = 3'b010,
    ST_STOP = 3'b110,
    ST_HOLD = 3'b111
  } uwfd_st_t;
  typedef struct packed {
    logic dma_rx_en;
    logic dma_tx_en;
    logic flow_en;
    logic brk;
    logic two_stop;
    logic par_stick;
    logic par_even;
    logic par_en;
    logic [1:0] wlen;
    logic fifo_en;
    logic rx_en;
    logic tx_en;
    logic [2:0] rx_lvl;
    logic [2:0] tx_lvl;
  } uwfd_ctrl_t;
  localparam uwfd_ctrl_t CTRL_RST = 18'h00000;
  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } uwfd_rxw_t;
  typedef struct packed {
    logic [4:0] rx_cnt;
    logic [4:0] tx_cnt;
    logic cts;
    logic tx_busy;
    logic rx_full;
    logic rx_empty;
    logic tx_full;
    logic tx_empty;
  } uwfd_stat_t;
  typedef struct packed {
    logic tx_done;
    logic pe;
    logic fe;
    logic brk;
    logic ovr;
  } uwfd_evt_t;
  localparam uwfd_evt_t EVT_RST = 5'h00;
endpackage
`default_nettype wire

// ---- design/uwfd_top.sv ----
// Contract
// - separate sixteen-entry transmit and receive fifos, byte-wide on transmit, byte plus break, framing and parity flags on receive
// - software can shrink each fifo to one byte, double-buffered behaviour
// - trigger levels 1/8, 1/4, 1/2, 3/4, 7/8 for level flags and bursts
// - five to eight data bits per frame, same setting at both ends
// - even, odd, stick or no parity generated and checked
// - one or two stop bits appended per character
// - send a line break and detect a received break
// - with flow control, send only while partner permits; signal own readiness
// - receive dma single when data present, burst at trigger level
// - transmit dma single when space free, burst at trigger level
// - separate dma request lines for transmit and receive
// - programmable bit rate up to three megabits per second
// - bit timing divided from the system clock, no link clock
// - level flags when fifos cross trigger, flag when transmission done
`default_nettype none
module uwfd_top
  import uwfd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_rxd,
  input wire logic i_cts_n,
  output logic [31:0] o_rdata,
  output logic o_txd,
  output logic o_rts_n,
  output logic o_dma_tx_single,
  output logic o_dma_tx_burst,
  output logic o_dma_rx_single,
  output logic o_dma_rx_burst,
  output logic o_irq_tx_lvl,
  output logic o_irq_rx_lvl,
  output logic o_irq_tx_done
);

  // trigger level in entries; a one-byte fifo triggers at one entry
  function automatic logic [4:0] lvl_of(input logic [2:0] code, input logic fifo_en);
    logic [4:0] v;
    v = CAP_ONE;
    if (fifo_en) begin
      case (code)
        3'h0: v = LVL_1_8;
        3'h1: v = LVL_1_4;
        3'h2: v = LVL_1_2;
        3'h3: v = LVL_3_4;
        default: v = LVL_7_8;
      endcase
    end
    return v;
  endfunction

  // parity over the active data bits only
  function automatic logic par_of(input logic [7:0] d, input uwfd_ctrl_t c);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - c.wlen));
    if (c.par_stick) begin
      return ~c.par_even;
    end
    return (^m) ^ ~c.par_even;
  endfunction

  uwfd_ctrl_t ctrl_q;
  uwfd_evt_t evt_q;
  logic [15:0] div_q;
  logic [15:0] bd_cnt_q;
  logic tick;
  logic [4:0] cap;
  logic [2:0] last_bit;
  logic [1:0] dshift;

  // synchronisers for the pins
  logic rxd_m_q;
  logic rxd_q;
  logic cts_m_q;
  logic cts_n_q;

  // fifos
  logic [7:0] tx_mem_q [DEPTH];
  uwfd_rxw_t rx_mem_q [DEPTH];
  logic [3:0] tx_wp_q;
  logic [3:0] tx_rp_q;
  logic [4:0] tx_cnt_q;
  logic [3:0] rx_wp_q;
  logic [3:0] rx_rp_q;
  logic [4:0] rx_cnt_q;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  uwfd_rxw_t rx_word;
  logic [4:0] tx_trig;
  logic [4:0] rx_trig;

  // transmitter
  uwfd_st_t tx_st_q;
  logic [7:0] tx_sh_q;
  logic [3:0] tx_tk_q;
  logic [2:0] tx_bit_q;
  logic tx_par_q;
  logic tx_stp_q;
  logic tx_line_q;
  logic tx_go;
  logic tx_done;

  // receiver
  uwfd_st_t rx_st_q;
  logic [7:0] rx_sh_q;
  logic [3:0] rx_tk_q;
  logic [2:0] rx_bit_q;
  logic rx_pe_q;
  logic rx_one_q;
  logic rx_stop;

  logic [31:0] rdata_d;
  uwfd_stat_t stat;

  assign cap = ctrl_q.fifo_en ? CAP_FULL : CAP_ONE;
  assign last_bit = 3'(3'h4 + {1'b0, ctrl_q.wlen});
  assign dshift = 2'h3 - ctrl_q.wlen;
  assign tx_full = tx_cnt_q >= cap;
  assign tx_empty = tx_cnt_q == 5'h00;
  assign rx_full = rx_cnt_q >= cap;
  assign rx_empty = rx_cnt_q == 5'h00;
  assign tx_trig = lvl_of(ctrl_q.tx_lvl, ctrl_q.fifo_en);
  assign rx_trig = lvl_of(ctrl_q.rx_lvl, ctrl_q.fifo_en);

  // two flops on each pin before anything looks at it
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rxd_m_q <= 1'b1;
      rxd_q <= 1'b1;
      cts_m_q <= 1'b1;
      cts_n_q <= 1'b1;
    end else begin
      rxd_m_q <= i_rxd;
      rxd_q <= rxd_m_q;
      cts_m_q <= i_cts_n;
      cts_n_q <= cts_m_q;
    end
  end

  // divider from system clock
  // divisor 1 gives 3.125 Mbit/s at 100 MHz, so the top rate is reachable
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      bd_cnt_q <= DIV_RST;
    end else if (tick) begin
      bd_cnt_q <= div_q;
    end else begin
      bd_cnt_q <= bd_cnt_q - 16'h0001;
    end
  end
  assign tick = bd_cnt_q == 16'h0000;

  // control registers written by software
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl_q <= CTRL_RST;
      div_q <= DIV_RST;
    end else if (i_wr) begin
      if (i_addr == A_CTRL) begin
        ctrl_q <= i_wdata[$bits(uwfd_ctrl_t)-1:0];
      end
      if (i_addr == A_BAUD) begin
        div_q <= i_wdata[15:0];
      end
    end
  end

  // transmit fifo; writes to a full fifo are dropped
  assign tx_push = i_wr && (i_addr == A_DATA) && !tx_full;
  always_ff @(posedge i_clk) begin
    if (tx_push) begin
      tx_mem_q[tx_wp_q] <= i_wdata[7:0];
    end
  end
  // fill limit follows the selected depth
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      tx_wp_q <= 4'h0;
      tx_rp_q <= 4'h0;
      tx_cnt_q <= 5'h00;
    end else begin
      if (tx_push) begin
        tx_wp_q <= tx_wp_q + 4'h1;
      end
      if (tx_pop) begin
        tx_rp_q <= tx_rp_q + 4'h1;
      end
      tx_cnt_q <= 5'(tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop});
    end
  end

  // receive fifo; a read of data pops one entry
  assign rx_pop = i_rd && (i_addr == A_DATA) && !rx_empty;
  always_ff @(posedge i_clk) begin
    if (rx_push && !rx_full) begin
      rx_mem_q[rx_wp_q] <= rx_word;
    end
  end
  // receive fill limit follows the selected depth
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_wp_q <= 4'h0;
      rx_rp_q <= 4'h0;
      rx_cnt_q <= 5'h00;
    end else begin
      if (rx_push && !rx_full) begin
        rx_wp_q <= rx_wp_q + 4'h1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 4'h1;
      end
      rx_cnt_q <= 5'(rx_cnt_q + {4'h0, rx_push && !rx_full} - {4'h0, rx_pop});
    end
  end

  // hold off starting a frame while the partner is not ready
  assign tx_go = tick && ctrl_q.tx_en && !tx_empty && !ctrl_q.brk && (!ctrl_q.flow_en || !cts_n_q);
  assign tx_pop = (tx_st_q == ST_IDLE) && tx_go;
  assign tx_done = tick && (tx_tk_q == TK_END) && (tx_st_q == ST_STOP)
                   && (!ctrl_q.two_stop || tx_stp_q) && tx_empty;

  // transmit sequencer, advancing once per oversample tick
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      tx_st_q <= ST_IDLE;
      tx_sh_q <= 8'h00;
      tx_tk_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_par_q <= 1'b0;
      tx_stp_q <= 1'b0;
      tx_line_q <= 1'b1;
    end else begin
      unique case (tx_st_q)
        ST_IDLE: begin
          tx_tk_q <= 4'h0;
          // low start bit opens the frame
          if (tx_go) begin
            tx_sh_q <= tx_mem_q[tx_rp_q];
            tx_par_q <= par_of(tx_mem_q[tx_rp_q], ctrl_q);
            tx_line_q <= 1'b0;
            tx_st_q <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            tx_tk_q <= tx_tk_q + 4'h1;
            if (tx_tk_q == TK_END) begin
              tx_line_q <= tx_sh_q[0];
              tx_bit_q <= 3'h0;
              tx_st_q <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (tick) begin
            tx_tk_q <= tx_tk_q + 4'h1;
            if (tx_tk_q == TK_END) begin
              if (tx_bit_q == last_bit) begin
                tx_line_q <= ctrl_q.par_en ? tx_par_q : 1'b1;
                tx_stp_q <= 1'b0;
                tx_st_q <= ctrl_q.par_en ? ST_PAR : ST_STOP;
              end else begin
                tx_sh_q <= tx_sh_q >> 1;
                tx_line_q <= tx_sh_q[1];
                tx_bit_q <= tx_bit_q + 3'h1;
              end
            end
          end
        end
        ST_PAR: begin
          if (tick) begin
            tx_tk_q <= tx_tk_q + 4'h1;
            if (tx_tk_q == TK_END) begin
              tx_line_q <= 1'b1;
              tx_st_q <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            tx_tk_q <= tx_tk_q + 4'h1;
            if (tx_tk_q == TK_END) begin
              if (ctrl_q.two_stop && !tx_stp_q) begin
                tx_stp_q <= 1'b1;
              end else begin
                tx_st_q <= ST_IDLE;
              end
            end
          end
        end
        default: begin
          tx_st_q <= ST_IDLE;
          tx_line_q <= 1'b1;
        end
      endcase
    end
  end

  // receive sequencer; start is checked at its centre, then a full bit per sample
  assign rx_stop = tick && (rx_st_q == ST_STOP) && (rx_tk_q == TK_END);
  assign rx_push = rx_stop;
  always_comb begin
    rx_word.data = rx_sh_q >> dshift;
    rx_word.pe = ctrl_q.par_en && rx_pe_q;
    rx_word.fe = !rxd_q;
    // all-zero frame including stop is a break
    rx_word.brk = !rxd_q && !rx_one_q;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_st_q <= ST_IDLE;
      rx_sh_q <= 8'h00;
      rx_tk_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_pe_q <= 1'b0;
      rx_one_q <= 1'b0;
    end else begin
      unique case (rx_st_q)
        ST_IDLE: begin
          rx_tk_q <= 4'h0;
          rx_one_q <= 1'b0;
          rx_bit_q <= 3'h0;
          if (tick && ctrl_q.rx_en && !rxd_q) begin
            rx_st_q <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            rx_tk_q <= rx_tk_q + 4'h1;
            // recheck start at its centre to reject glitches
            if (rx_tk_q == TK_MID) begin
              rx_tk_q <= 4'h0;
              rx_st_q <= rxd_q ? ST_IDLE : ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (tick) begin
            rx_tk_q <= rx_tk_q + 4'h1;
            // sample a full bit after the previous centre
            if (rx_tk_q == TK_END) begin
              rx_sh_q <= {rxd_q, rx_sh_q[7:1]};
              rx_one_q <= rx_one_q | rxd_q;
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == last_bit) begin
                rx_st_q <= ctrl_q.par_en ? ST_PAR : ST_STOP;
              end
            end
          end
        end
        ST_PAR: begin
          if (tick) begin
            rx_tk_q <= rx_tk_q + 4'h1;
            if (rx_tk_q == TK_END) begin
              rx_pe_q <= rxd_q ^ par_of(rx_sh_q >> dshift, ctrl_q);
              rx_one_q <= rx_one_q | rxd_q;
              rx_st_q <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            rx_tk_q <= rx_tk_q + 4'h1;
            if (rx_tk_q == TK_END) begin
              rx_pe_q <= 1'b0;
              // a low stop waits for the line to rise, so one break is one entry
              rx_st_q <= rxd_q ? ST_IDLE : ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (rxd_q) begin
            rx_st_q <= ST_IDLE;
          end
        end
        default: begin
          rx_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      evt_q <= EVT_RST;
    end else begin
      if (i_wr && (i_addr == A_EVT)) begin
        evt_q <= evt_q & ~i_wdata[$bits(uwfd_evt_t)-1:0];
      end
      if (rx_push && rx_full) begin
        evt_q.ovr <= 1'b1;
      end
      if (rx_push && rx_word.brk) begin
        evt_q.brk <= 1'b1;
      end
      if (rx_push && rx_word.fe) begin
        evt_q.fe <= 1'b1;
      end
      if (rx_push && rx_word.pe) begin
        evt_q.pe <= 1'b1;
      end
      if (tx_done) begin
        evt_q.tx_done <= 1'b1;
      end
    end
  end

  // read mux; data appears in the cycle after the strobe
  always_comb begin
    stat.rx_cnt = rx_cnt_q;
    stat.tx_cnt = tx_cnt_q;
    stat.cts = !cts_n_q;
    stat.tx_busy = tx_st_q != ST_IDLE;
    stat.rx_full = rx_full;
    stat.rx_empty = rx_empty;
    stat.tx_full = tx_full;
    stat.tx_empty = tx_empty;
    rdata_d = 32'h00000000;
    unique case (i_addr)
      A_DATA: rdata_d = rx_empty ? 32'h00000000 : 32'(rx_mem_q[rx_rp_q]);
      A_CTRL: rdata_d = 32'(ctrl_q);
      A_BAUD: rdata_d = 32'(div_q);
      A_STAT: rdata_d = 32'(stat);
      A_EVT: rdata_d = 32'(evt_q);
      default: rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= i_rd ? rdata_d : 32'h00000000;
    end
  end

  // line and flow pins
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_txd <= 1'b1;
      o_rts_n <= 1'b1;
    end else begin
      o_txd <= tx_line_q && !ctrl_q.brk;
      // ready while the receive fifo has room
      o_rts_n <= ctrl_q.flow_en ? rx_full : 1'b0;
    end
  end

  // dma requests on separate lines per direction
  // dma and level flags, one clock behind the counts
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_dma_tx_single <= 1'b0;
      o_dma_tx_burst <= 1'b0;
      o_dma_rx_single <= 1'b0;
      o_dma_rx_burst <= 1'b0;
      o_irq_tx_lvl <= 1'b0;
      o_irq_rx_lvl <= 1'b0;
      o_irq_tx_done <= 1'b0;
    end else begin
      // transmit requests on space and level
      o_dma_tx_single <= ctrl_q.dma_tx_en && !tx_full;
      o_dma_tx_burst <= ctrl_q.dma_tx_en && (tx_cnt_q <= tx_trig);
      // receive requests on data and level
      o_dma_rx_single <= ctrl_q.dma_rx_en && !rx_empty;
      o_dma_rx_burst <= ctrl_q.dma_rx_en && (rx_cnt_q >= rx_trig);
      // level flags use the programmed trigger
      o_irq_tx_lvl <= tx_cnt_q <= tx_trig;
      o_irq_rx_lvl <= rx_cnt_q >= rx_trig;
      // done flag follows its sticky event
      o_irq_tx_done <= evt_q.tx_done;
    end
  end

endmodule
`default_nettype wire

// ---- sim/uwfd_monitor.sv ----
`default_nettype none
module uwfd_monitor
  import uwfd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [4:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_txd,
  input wire logic o_rts_n,
  input wire logic o_dma_rx_single,
  input wire logic o_dma_rx_burst,
  input wire logic o_dma_tx_burst,
  input wire logic o_irq_tx_lvl,
  input wire logic o_irq_rx_lvl,
  input wire logic o_irq_tx_done
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  rdata_idle_a:
    assert property (!i_rd |=> o_rdata == 32'h0) else $error("read data outside the read window");
  unmapped_read_a:
    assert property (i_rd && (i_addr > A_EVT || i_addr[1:0] != 2'b00) |=> o_rdata == 32'h0)
    else $error("unmapped address returned data");
  rdata_upper_a:
    assert property (i_rd |=> o_rdata[31:19] == 13'h0) else $error("read data upper bits set");
  // reset idles the line; watched through reset itself
  reset_idle_a:
    assert property (disable iff (1'b0) !i_resetn |=> o_txd && o_rts_n && !o_dma_rx_single && !o_irq_tx_done)
    else $error("outputs not at reset values");
  rx_burst_pair_a:
    assert property (o_dma_rx_burst |-> o_dma_rx_single && o_irq_rx_lvl) else $error("rx burst without data");
  tx_burst_level_a:
    assert property (o_dma_tx_burst |-> o_irq_tx_lvl) else $error("tx burst above trigger");
  // a low bit stays low for eight clocks after it falls
  start_bit_a:
    assert property ($fell(o_txd) |=> !o_txd [*8]) else $error("low bit too short");
  // a high bit stays high for eight clocks after it rises
  high_bit_a:
    assert property ($rose(o_txd) |=> o_txd [*8]) else $error("high bit too short");
endmodule
bind uwfd_top uwfd_monitor u_mon (.i_clk, .i_resetn, .i_addr, .i_rd, .o_rdata, .o_txd, .o_rts_n,
  .o_dma_rx_single, .o_dma_rx_burst, .o_dma_tx_burst, .o_irq_tx_lvl, .o_irq_rx_lvl, .o_irq_tx_done);
`default_nettype wire

// ---- sim/uwfd_peer.sv ----
`default_nettype none
module uwfd_peer (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd,
  output logic o_cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int rlen = 10;
  int nfr = 0;
  logic [10:0] cap;
  time t_last = 0;
  time gap = 0;
  // idle line high, sending permitted
  initial begin
    o_rxd = 1'b1;
    o_cts_n = 1'b0;
  end
  // permit or hold the far transmitter
  task automatic set_cts(input logic v);
    @(posedge i_clk);
    o_cts_n <= v;
  endtask
  // low start, bits lsb first, then idle high
  task automatic send(input logic [10:0] f, input int n);
    @(posedge i_clk);
    o_rxd <= 1'b0;
    repeat (16) @(posedge i_clk);
    for (int k = 0; k < n; k++) begin
      o_rxd <= f[k];
      repeat (16) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
    repeat (32) @(posedge i_clk);
  endtask
  // sample at bit centres; assumes sixteen clocks a bit
  always begin
    @(negedge i_txd);
    gap = $time - t_last;
    t_last = $time;
    cap = '0;
    repeat (8) @(posedge i_clk);
    for (int k = 0; k < rlen; k++) begin
      repeat (16) @(posedge i_clk);
      cap[k] = i_txd;
    end
    nfr++;
  end
endmodule
`default_nettype wire

// ---- sim/uwfd_top_test.sv ----
`default_nettype none
module uwfd_top_test
  import uwfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic rxd, cts_n, txd, rts_n, tx_single, tx_burst, rx_single, rx_burst, tx_lvl, rx_lvl, tx_done;
  int err_count = 0, n_checks = 0, cyc = 0, n, n0, dg;
  uwfd_ctrl_t c;
  uwfd_stat_t s;
  logic [10:0] f;
  logic [7:0] b;
  // {two_stop, stick, even, parity, wlen}
  logic [5:0] cfg [5] = '{6'h00, 6'h0D, 6'h26, 6'h17, 6'h3F};
  always #5 clk = ~clk;
  uwfd_top DUT (.i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .i_rxd(rxd), .i_cts_n(cts_n), .o_rdata(rdata), .o_txd(txd), .o_rts_n(rts_n), .o_dma_tx_single(tx_single),
    .o_dma_tx_burst(tx_burst), .o_dma_rx_single(rx_single), .o_dma_rx_burst(rx_burst), .o_irq_tx_lvl(tx_lvl),
    .o_irq_rx_lvl(rx_lvl), .o_irq_tx_done(tx_done));
  uwfd_peer p (.i_clk(clk), .i_txd(txd), .o_rxd(rxd), .o_cts_n(cts_n));
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_fr(input int k);
    for (int i = 0; i < 4000 && p.nfr < k; i++) @(posedge clk);
  endtask
  // expected bits after the start bit, unused upper bits zero
  function automatic logic [10:0] frame(input logic [7:0] d, input logic [5:0] g, output int n);
    logic [7:0] m;
    m = d & (8'hFF >> (2'd3 - g[1:0]));
    n = 5 + int'(g[1:0]);
    frame = 11'(m) | (11'h7FF << n);
    if (g[2]) begin
      frame[n] = g[4] ? ~g[3] : ^m ^ ~g[3];
      n++;
    end
    n = n + 1 + int'(g[5]);
    frame = frame & ~(11'h7FF << n);
  endfunction
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // reset values and an unmapped place
    rd_reg(A_CTRL, v);
    chk(v, 32'h0);
    rd_reg(A_BAUD, v);
    chk(v, 32'h35);
    rd_reg(A_EVT, v);
    chk(v, 32'h0);
    rd_reg(5'h14, v);
    chk(v, 32'h0);
    s = '0;
    s.cts = 1'b1;
    s.rx_empty = 1'b1;
    s.tx_empty = 1'b1;
    rd_reg(A_STAT, v);
    chk(v, 32'(s));
    chk(32'(rts_n), 32'h0);
    // one-byte depth with the partner holding us off
    wr_reg(A_BAUD, 32'h0);
    p.set_cts(1'b1);
    c = CTRL_RST;
    c.tx_en = 1'b1;
    c.flow_en = 1'b1;
    wr_reg(A_CTRL, 32'(c));
    p.rlen = 6;
    n0 = p.nfr;
    wr_reg(A_DATA, 32'h11);
    wr_reg(A_DATA, 32'h22);
    repeat (200) @(posedge clk);
    rd_reg(A_STAT, v);
    s = uwfd_stat_t'(v[15:0]);
    chk(32'({s.tx_cnt, s.cts, s.tx_full}), 32'h5);
    chk(32'(p.nfr - n0), 32'h0);
    p.set_cts(1'b0);
    repeat (300) @(posedge clk);
    chk(32'(p.nfr - n0), 32'h1);
    chk(32'(p.cap), 32'(frame(8'h11, 6'h00, n)));
    // each word length, parity kind and stop count, two frames out and one in
    for (int i = 0; i < 5; i++) begin
      c = CTRL_RST;
      c.tx_en = 1'b1;
      c.rx_en = 1'b1;
      c.fifo_en = 1'b1;
      {c.two_stop, c.par_stick, c.par_even, c.par_en, c.wlen} = cfg[i];
      wr_reg(A_CTRL, 32'(c));
      b = 8'hA3 ^ 8'(i * 17);
      f = frame(b, cfg[i], n);
      p.rlen = n;
      n0 = p.nfr;
      wr_reg(A_DATA, 32'(b));
      wr_reg(A_DATA, 32'(b));
      wait_fr(n0 + 2);
      chk(32'(p.cap), 32'(f));
      dg = int'(p.gap / 10) - 16 * (n + 1);
      chk(32'(dg > 0 && dg < 17), 32'h1);
      p.send(f, n);
      rd_reg(A_DATA, v);
      chk(v, 32'(f[7:0] & (8'hFF >> (2'd3 - cfg[i][1:0]))));
      chk(32'(tx_done), 32'h1);
      wr_reg(A_EVT, 32'h1F);
    end
    repeat (3) @(posedge clk);
    #1;
    chk(32'(tx_done), 32'h0);
    // line break out and in
    c = CTRL_RST;
    c.tx_en = 1'b1;
    c.rx_en = 1'b1;
    c.fifo_en = 1'b1;
    c.brk = 1'b1;
    wr_reg(A_CTRL, 32'(c));
    p.send(11'h000, 6);
    chk(32'(txd), 32'h0);
    c.brk = 1'b0;
    wr_reg(A_CTRL, 32'(c));
    rd_reg(A_DATA, v);
    chk(v, 32'h600);
    rd_reg(A_EVT, v);
    chk(v, 32'h6);
    wr_reg(A_EVT, 32'h1F);
    // fill both fifos past full while watching levels and requests
    c = CTRL_RST;
    c.rx_en = 1'b1;
    c.fifo_en = 1'b1;
    c.flow_en = 1'b1;
    c.dma_rx_en = 1'b1;
    c.dma_tx_en = 1'b1;
    c.wlen = 2'h3;
    c.rx_lvl = 3'h1;
    wr_reg(A_CTRL, 32'(c));
    for (int k = 1; k <= 17; k++) begin
      wr_reg(A_DATA, 32'(k));
      repeat (2) @(posedge clk);
      #1;
      chk(32'({tx_single, tx_burst, tx_lvl}), 32'({k < 16, k <= 2, k <= 2}));
    end
    for (int k = 1; k <= 17; k++) begin
      f = frame(8'(k), 6'h03, n);
      p.send(f, n);
      chk(32'({rx_single, rx_burst, rx_lvl, rts_n}), 32'({1'b1, k >= 4, k >= 4, k >= 16}));
    end
    rd_reg(A_EVT, v);
    chk(v, 32'h1);
    for (int k = 1; k <= 16; k++) begin
      rd_reg(A_DATA, v);
      chk(v, 32'(k));
    end
    rd_reg(A_DATA, v);
    chk(v, 32'h0);
    chk(32'(rx_single), 32'h0);
    // drain the transmit fifo onto the line
    c.tx_en = 1'b1;
    p.rlen = 9;
    n0 = p.nfr;
    wr_reg(A_CTRL, 32'(c));
    wait_fr(n0 + 16);
    chk(32'(p.cap), 32'(frame(8'h10, 6'h03, n)));
    repeat (40) @(posedge clk);
    rd_reg(A_STAT, v);
    s = uwfd_stat_t'(v[15:0]);
    chk(32'(s.tx_empty), 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
